// ==== gpio_led_indicator_pins.sv ====
// Three multipurpose pins: GPIO or speed, link/activity, duplex LEDs.
// Assumes link status inputs come from the MAC/PHY on sys_clk.
`timescale 1ns/1ps
`include "gpio_led_map.svh"

// Overview of operation
// - each of three pins is push-pull output, open-drain output, input or LED
// - in LED mode a pin sinks low to light, releases otherwise
// - speed LED low at 100Mb; high during negotiation, no cable, 10Mb
// - link/activity LED low while link valid and no blink running
// - activity with link up drives link/activity LED high for 80 ms
// - after each blink, LED stays low 80 ms; repeats only on new activity
// - duplex LED low during full-duplex link, released high otherwise
module gpio_led_indicator_pins
	import gpio_led_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   rst_n,
	input  wire logic [`PIN_COUNT-1:0]  pinIn,
	output logic      [`PIN_COUNT-1:0]  pinOut,
	output logic      [`PIN_COUNT-1:0]  pinOutEn,
	input  wire pin_mode_t              pinMode [`PIN_COUNT],
	input  wire logic [`PIN_COUNT-1:0]  gpioDataOut,
	output logic      [`PIN_COUNT-1:0]  gpioDataIn,
	input  wire logic                   linkUp,
	input  wire logic                   speed100,
	input  wire logic                   autoNegBusy,
	input  wire logic                   fullDuplex,
	input  wire logic                   txActivity,
	input  wire logic                   rxActivity,
	output logic                        speed_led_n,
	output logic                        link_activity_led_n,
	output logic                        full_duplex_led_n
);

	localparam logic [`BLINK_CNT_W-1:0] BLINK_LAST =
		`BLINK_CNT_W'(`BLINK_CYCLES - 1);

	blink_state_t            state;
	blink_state_t            next_state;
	logic [`BLINK_CNT_W-1:0] count;
	logic [`BLINK_CNT_W-1:0] next_count;
	logic                    pending;
	logic                    next_pending;
	logic                    next_speed;
	logic                    next_link;
	logic                    next_duplex;
	logic                    activity;
	logic [`PIN_COUNT-1:0]   ledLevel;

	assign activity = txActivity | rxActivity;

	// ---------------------------------------------------------------
	// Activity blink sequencer
	// ---------------------------------------------------------------
	always_comb begin
		next_state   = state;
		next_count   = count;
		// Activity seen during a blink is held for the next one
		next_pending = pending | (activity & linkUp);
		case (state)
			BLINK_IDLE: begin
				next_count = '0;
				if (linkUp && next_pending) begin
					next_state   = BLINK_HIGH;
					next_pending = 1'b0;
				end
			end
			BLINK_HIGH: begin
				next_count = count + 1'b1;
				if (count == BLINK_LAST) begin
					next_state = BLINK_LOW;
					next_count = '0;
				end
			end
			BLINK_LOW: begin
				next_count = count + 1'b1;
				if (count == BLINK_LAST) begin
					next_state = BLINK_IDLE;
					next_count = '0;
				end
			end
			default: begin
				next_state = BLINK_IDLE;
				next_count = '0;
			end
		endcase
		// Link loss aborts any blink
		if (!linkUp) begin
			next_state   = BLINK_IDLE;
			next_count   = '0;
			next_pending = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Indicator levels
	// ---------------------------------------------------------------
	always_comb begin
		next_speed  = ~(linkUp & speed100 & ~autoNegBusy);
		next_link   = ~linkUp | (next_state == BLINK_HIGH);
		next_duplex = ~(linkUp & fullDuplex);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state               <= BLINK_IDLE;
			count               <= '0;
			pending             <= 1'b0;
			speed_led_n         <= 1'b1;
			link_activity_led_n <= 1'b1;
			full_duplex_led_n   <= 1'b1;
		end else begin
			state               <= next_state;
			count               <= next_count;
			pending             <= next_pending;
			speed_led_n         <= next_speed;
			link_activity_led_n <= next_link;
			full_duplex_led_n   <= next_duplex;
		end
	end

	assign ledLevel[`SPEED_PIN]  = speed_led_n;
	assign ledLevel[`LINK_PIN]   = link_activity_led_n;
	assign ledLevel[`DUPLEX_PIN] = full_duplex_led_n;

	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `PIN_COUNT; i++) begin : g_pin
			pin_driver u_pin (
				.sys_clk  (sys_clk),
				.rst_n    (rst_n),
				.mode     (pinMode[i]),
				.dataOut  (gpioDataOut[i]),
				.ledLevel (ledLevel[i]),
				.pinIn    (pinIn[i]),
				.pinOut   (pinOut[i]),
				.pinOutEn (pinOutEn[i]),
				.dataIn   (gpioDataIn[i])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	// Gap counter runs from the end of the last high phase
	int unsigned highRun;
	int unsigned lowRun;
	logic        wasHigh;
	logic        afterBlink;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			highRun    <= 0;
			lowRun     <= 0;
			wasHigh    <= 1'b0;
			afterBlink <= 1'b0;
		end else begin
			highRun    <= (state == BLINK_HIGH) ? highRun + 1 : 0;
			lowRun     <= (state == BLINK_HIGH) ? 0 : lowRun + 1;
			wasHigh    <= (state == BLINK_HIGH);
			// Link loss restarts the sequence, so no gap is owed
			afterBlink <= linkUp & (afterBlink | (state == BLINK_HIGH));
		end
	end

	property p_speed;
		@(posedge sys_clk) disable iff (!rst_n)
		(linkUp && speed100 && !autoNegBusy) |=> !speed_led_n;
	endproperty
	a_speed: assert property (p_speed) else $error("speed led");

	property p_speed_off;
		@(posedge sys_clk) disable iff (!rst_n)
		(!speed100 || autoNegBusy || !linkUp) |=> speed_led_n;
	endproperty
	a_speed_off: assert property (p_speed_off)
		else $error("speed led not off");

	property p_link_solid;
		@(posedge sys_clk) disable iff (!rst_n)
		(linkUp && state == BLINK_IDLE && !pending && !activity)
		|=> !link_activity_led_n;
	endproperty
	a_link_solid: assert property (p_link_solid)
		else $error("link led not lit");

	property p_blink_start;
		@(posedge sys_clk) disable iff (!rst_n)
		(linkUp && activity && state == BLINK_IDLE) ##1 linkUp
		|-> link_activity_led_n;
	endproperty
	a_blink_start: assert property (p_blink_start)
		else $error("blink did not start");

	property p_high_len;
		@(posedge sys_clk) disable iff (!rst_n)
		highRun <= `BLINK_CYCLES;
	endproperty
	a_high_len: assert property (p_high_len)
		else $error("blink high too long");

	property p_low_min;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == BLINK_LOW && linkUp) |-> !link_activity_led_n;
	endproperty
	a_low_min: assert property (p_low_min)
		else $error("blink low gap broken");

	property p_high_exact;
		@(posedge sys_clk) disable iff (!rst_n)
		(wasHigh && state == BLINK_LOW) |-> (highRun == `BLINK_CYCLES);
	endproperty
	a_high_exact: assert property (p_high_exact)
		else $error("blink high length wrong");

	property p_gap;
		@(posedge sys_clk) disable iff (!rst_n)
		(state == BLINK_HIGH && !wasHigh && afterBlink)
		|-> (lowRun >= `BLINK_CYCLES);
	endproperty
	a_gap: assert property (p_gap)
		else $error("blink gap too short");

	property p_duplex;
		@(posedge sys_clk) disable iff (!rst_n)
		(linkUp && fullDuplex) |=> !full_duplex_led_n;
	endproperty
	a_duplex: assert property (p_duplex) else $error("duplex led");

	property p_led_od;
		@(posedge sys_clk) disable iff (!rst_n)
		(pinMode[`LINK_PIN] == `MODE_LED) ##1
		(pinMode[`LINK_PIN] == `MODE_LED)
		|-> (pinOut[`LINK_PIN] == 1'b0 &&
		     pinOutEn[`LINK_PIN] == !$past(link_activity_led_n));
	endproperty
	a_led_od: assert property (p_led_od)
		else $error("led pin not open drain");

	property p_gpo;
		@(posedge sys_clk) disable iff (!rst_n)
		(pinMode[0] == `MODE_PUSH_PULL) |=>
		(pinOutEn[0] && pinOut[0] == $past(gpioDataOut[0]));
	endproperty
	a_gpo: assert property (p_gpo)
		else $error("push-pull output wrong");

	c_blink: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state == BLINK_HIGH ##1 state == BLINK_LOW);
	c_repeat: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state == BLINK_LOW ##1 state == BLINK_IDLE ##1 state == BLINK_HIGH);
	c_full: cover property (@(posedge sys_clk) disable iff (!rst_n)
		!speed_led_n && !full_duplex_led_n);

endmodule : gpio_led_indicator_pins

// ==== gpio_led_indicator_pins_tb.sv ====
// Self-checking bench for the three multipurpose pins.
// Assumes the 80 ms blink define is left as is; only its start is seen.
`timescale 1ns/1ps

module gpio_led_indicator_pins_tb;
	import gpio_led_pkg::*;
	logic      sys_clk, rst_n, linkUp, speed100, autoNegBusy;
	logic      fullDuplex, txActivity, rxActivity;
	logic      speed_led_n, link_activity_led_n, full_duplex_led_n;
	logic [2:0] pinIn, pinOut, pinOutEn, gpioDataOut, gpioDataIn;
	logic [2:0] extLevel, extEn;
	pin_mode_t pinMode [3];
	int        error_cnt, checked;
	wire [2:0] leds = {full_duplex_led_n, link_activity_led_n, speed_led_n};

	gpio_led_indicator_pins gpio_led_indicator_pins_inst (.sys_clk(sys_clk),
		.rst_n(rst_n), .pinIn(pinIn), .pinOut(pinOut), .pinOutEn(pinOutEn),
		.pinMode(pinMode), .gpioDataOut(gpioDataOut),
		.gpioDataIn(gpioDataIn), .linkUp(linkUp), .speed100(speed100),
		.autoNegBusy(autoNegBusy), .fullDuplex(fullDuplex),
		.txActivity(txActivity), .rxActivity(rxActivity),
		.speed_led_n(speed_led_n), .link_activity_led_n(link_activity_led_n),
		.full_duplex_led_n(full_duplex_led_n));
	pad_model pad_model_inst (.pinOut(pinOut), .pinOutEn(pinOutEn),
		.extLevel(extLevel), .extEn(extEn), .padLevel(pinIn));

	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task ticks(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : ticks
	task chk(input string what, input logic [2:0] expV, input logic [2:0] got);
		checked++;
		if (got !== expV) begin
			error_cnt++;
			$display("[ERR] %s exp %b got %b", what, expV, got);
		end
	endtask : chk
	task conclude;
		if (error_cnt == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		chk("leds", 3'h7, leds);
		chk("outEn", 3'h0, pinOutEn);
		chk("out", 3'h0, pinOut);
		chk("dataIn", 3'h0, gpioDataIn);
	endtask : t_reset
	task t_speed;
		for (int i = 0; i < 8; i++) begin
			{linkUp, speed100, autoNegBusy} = i[2:0];
			ticks(2);
			chk("speed", {2'h0, ~(i == 6)}, leds & 3'h1);
		end
	endtask : t_speed
	task t_duplex;
		for (int i = 0; i < 4; i++) begin
			{linkUp, fullDuplex} = i[1:0];
			ticks(2);
			chk("duplex", {~(i == 3), 2'h0}, leds & 3'h4);
		end
	endtask : t_duplex
	task t_activity;
		linkUp = 1;
		ticks(2);
		chk("linkLed", 3'h0, {2'h0, link_activity_led_n});
		txActivity = 1;
		ticks(1);
		txActivity = 0;
		chk("blinkTx", 3'h1, {2'h0, link_activity_led_n});
		ticks(1000);
		chk("blinkHold", 3'h1, {2'h0, link_activity_led_n});
		linkUp = 0;
		rxActivity = 1;
		ticks(3);
		rxActivity = 0;
		chk("linkDown", 3'h1, {2'h0, link_activity_led_n});
		linkUp = 1;
		ticks(2);
		chk("noStale", 3'h0, {2'h0, link_activity_led_n});
		rxActivity = 1;
		ticks(1);
		rxActivity = 0;
		chk("blinkRx", 3'h1, {2'h0, link_activity_led_n});
		linkUp = 0;
		ticks(2);
	endtask : t_activity
	task t_gpio;
		pinMode = '{2'h1, 2'h1, 2'h1};
		gpioDataOut = 3'h5;
		ticks(5);
		chk("ppEn", 3'h7, pinOutEn);
		chk("ppOut", 3'h5, pinOut);
		chk("ppIn", 3'h5, gpioDataIn);
		pinMode = '{2'h2, 2'h2, 2'h2};
		gpioDataOut = 3'h2;
		ticks(5);
		chk("odEn", 3'h5, pinOutEn);
		chk("odOut", 3'h0, pinOut);
		chk("odIn", 3'h2, gpioDataIn);
		pinMode = '{2'h0, 2'h0, 2'h0};
		extEn = 3'h7;
		extLevel = 3'h6;
		ticks(5);
		chk("inEn", 3'h0, pinOutEn);
		chk("inA", 3'h6, gpioDataIn);
		extLevel = 3'h3;
		ticks(5);
		chk("inB", 3'h3, gpioDataIn);
		extEn = 3'h0;
	endtask : t_gpio
	task t_led_pins;
		pinMode = '{2'h3, 2'h3, 2'h3};
		{linkUp, speed100, autoNegBusy, fullDuplex} = 4'h c;
		ticks(5);
		chk("ledEn", 3'h3, pinOutEn);
		chk("ledOut", 3'h0, pinOut);
		chk("ledPad", 3'h4, gpioDataIn);
		rst_n = 0;
		ticks(1);
		t_reset();
		rst_n = 1;
	endtask : t_led_pins

	initial begin
		#200_000;
		error_cnt++;
		conclude();
	end

	initial begin
		{rst_n, linkUp, speed100, autoNegBusy, fullDuplex} = '0;
		{txActivity, rxActivity, gpioDataOut, extLevel, extEn} = '0;
		pinMode = '{2'h0, 2'h0, 2'h0};
		error_cnt = 0;
		checked = 0;
		ticks(20);
		t_reset();
		rst_n = 1;
		t_speed();
		t_duplex();
		t_activity();
		t_gpio();
		t_led_pins();
		ticks(2);
		conclude();
	end
endmodule : gpio_led_indicator_pins_tb

// ==== gpio_led_map.svh ====
// Constants for the three multipurpose indicator/GPIO pins.
// Assumes a 100 MHz core clock; included by the package and the modules.
`ifndef GPIO_LED_MAP_SVH
`define GPIO_LED_MAP_SVH

`define PIN_COUNT        3
`define CLK_PERIOD_NS    10
`define BLINK_TIME_MS    80
// Cycles for 80 ms at the core clock rate
`define BLINK_CYCLES     ((`BLINK_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define BLINK_CNT_W      24
`define SPEED_PIN        0
`define LINK_PIN         1
`define DUPLEX_PIN       2
`define MODE_INPUT       2'h0
`define MODE_PUSH_PULL   2'h1
`define MODE_OPEN_DRAIN  2'h2
`define MODE_LED         2'h3

`endif

// ==== gpio_led_pkg.sv ====
// Types for the multipurpose pin block.
// Assumes gpio_led_map.svh is on the include path.
`include "gpio_led_map.svh"

package gpio_led_pkg;

	typedef logic [1:0] pin_mode_t;

	// One-hot states of the activity blink sequencer
	typedef enum logic [2:0] {
		BLINK_IDLE = 3'b001,
		BLINK_HIGH = 3'b010,
		BLINK_LOW  = 3'b100
	} blink_state_t;

endpackage : gpio_led_pkg

// ==== pad_model.sv ====
// Pad model: three pins, LED pull-ups and an external driver.
// Assumes an enable is high while its party drives the pad.
`timescale 1ns/1ps

module pad_model (
	input  wire logic [2:0] pinOut,
	input  wire logic [2:0] pinOutEn,
	input  wire logic [2:0] extLevel,
	input  wire logic [2:0] extEn,
	output logic      [2:0] padLevel
);
	// Released pad floats up through the LED resistor
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (pinOutEn[i])
				padLevel[i] = pinOut[i];
			else
				padLevel[i] = extEn[i] ? extLevel[i] : 1'b1;
		end
	end
endmodule : pad_model

// ==== pin_driver.sv ====
// One multipurpose pin: mode select, output drive and input sampling.
// Assumes the pad resolves level from out and outEn, high enable drives.
`timescale 1ns/1ps
`include "gpio_led_map.svh"

module pin_driver
	import gpio_led_pkg::*;
(
	input  wire logic      sys_clk,
	input  wire logic      rst_n,
	input  wire pin_mode_t mode,
	input  wire logic      dataOut,
	input  wire logic      ledLevel,
	input  wire logic      pinIn,
	output logic           pinOut,
	output logic           pinOutEn,
	output logic           dataIn
);

	logic syncA;
	logic syncB;
	logic next_pinOut;
	logic next_pinOutEn;

	// ---------------------------------------------------------------
	// Drive selection
	// ---------------------------------------------------------------
	always_comb begin
		next_pinOut   = 1'b0;
		next_pinOutEn = 1'b0;
		case (mode)
			`MODE_PUSH_PULL: begin
				next_pinOut   = dataOut;
				next_pinOutEn = 1'b1;
			end
			`MODE_OPEN_DRAIN: begin
				next_pinOutEn = ~dataOut;
			end
			`MODE_LED: begin
				// Sink only to light; released otherwise
				next_pinOutEn = ~ledLevel;
			end
			default: begin
				next_pinOutEn = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pinOut   <= 1'b0;
			pinOutEn <= 1'b0;
			syncA    <= 1'b0;
			syncB    <= 1'b0;
			dataIn   <= 1'b0;
		end else begin
			pinOut   <= next_pinOut;
			pinOutEn <= next_pinOutEn;
			syncA    <= pinIn;
			syncB    <= syncA;
			dataIn   <= syncB;
		end
	end

endmodule : pin_driver
